// >>> lwbh_consts.svh
// Constants for the load word, byte and halfword decode and execute unit
`ifndef LWBH_CONSTS_SVH
`define LWBH_CONSTS_SVH

`define LWBH_XLEN           32
`define LWBH_ILEN           16
`define LWBH_RIDX_W         4
`define LWBH_FIELD_W        3

// Opcode prefixes
`define LWBH_OP7_MSB        15
`define LWBH_OP7_LSB        9
`define LWBH_OP5_MSB        15
`define LWBH_OP5_LSB        11
`define LWBH_OP7_WORD_REG   7'h2C
`define LWBH_OP7_HALF_REG   7'h2D
`define LWBH_OP7_BYTE_REG   7'h2E
`define LWBH_OP5_WORD_IMM   5'h0D
`define LWBH_OP5_BYTE_IMM   5'h0F
`define LWBH_OP5_HALF_IMM   5'h11

// Field positions
`define LWBH_OFFS_MSB       8
`define LWBH_OFFS_LSB       6
`define LWBH_IMM_MSB        10
`define LWBH_IMM_LSB        6
`define LWBH_BASE_MSB       5
`define LWBH_BASE_LSB       3
`define LWBH_DEST_MSB       2
`define LWBH_DEST_LSB       0

// Immediate extension widths
`define LWBH_IMM_W          5
`define LWBH_IMM_PAD_B      27
`define LWBH_IMM_PAD_H      26
`define LWBH_IMM_PAD_W      25
`define LWBH_SCALE_H        1'h0
`define LWBH_SCALE_W        2'h0

// Data lanes and zero extension
`define LWBH_BYTE_MSB       7
`define LWBH_HALF_MSB       15
`define LWBH_PAD_B          24'h000000
`define LWBH_PAD_H          16'h0000
`define LWBH_LANES          4
`define LWBH_LANE_W         8
`define LWBH_KEEP_B         4'h1
`define LWBH_KEEP_H         4'h3
`define LWBH_KEEP_W         4'hF
`define LWBH_ZERO8          8'h00

// Program counter index and state bit
`define LWBH_PC_IDX         4'hF
`define LWBH_TBIT           0
`define LWBH_TBIT_CLR       32'hFFFFFFFE

`define LWBH_ZERO32         32'h00000000
`define LWBH_ZERO4          4'h0

`endif

// >>> lwbh_pkg.sv
// Types shared by the load unit and its decoder
package lwbh_pkg;

    typedef enum logic [1:0] {
        LWBH_BYTE,
        LWBH_HALF,
        LWBH_WORD
    } lwbh_size_t;

    typedef enum logic [1:0] {
        LWBH_IDLE,
        LWBH_LOAD
    } lwbh_fsm_t;

    typedef struct packed {
        lwbh_fsm_t   fsm;
        lwbh_size_t  size;
        logic [3:0]  dest;
        logic [31:0] addr;
        logic        rf_we;
        logic [3:0]  rf_waddr;
        logic [31:0] rf_wdata;
        logic        br;
        logic [31:0] br_tgt;
        logic        fault;
        logic        miss;
    } lwbh_state_t;

endpackage

// >>> lwbh_decode.sv
// Opcode and field decoder for the load family
`timescale 1ns/1ps
`include "lwbh_consts.svh"

module lwbh_decode
    import lwbh_pkg::*;
(
    input  wire logic [15:0] instr,
    output lwbh_size_t       size,
    output logic             hit,
    output logic             reg_off,
    output logic [31:0]      imm32,
    output logic [2:0]       dest_f,
    output logic [2:0]       base_f,
    output logic [2:0]       offs_f
);

    logic [6:0] op7;
    logic [4:0] op5;
    logic [4:0] short_immediate_field;

    // Opcode prefixes, immediate and register fields taken as plain unsigned bit slices
    assign op7    = instr[`LWBH_OP7_MSB:`LWBH_OP7_LSB];
    assign op5    = instr[`LWBH_OP5_MSB:`LWBH_OP5_LSB];
    assign short_immediate_field   = instr[`LWBH_IMM_MSB:`LWBH_IMM_LSB];
    assign offs_f = instr[`LWBH_OFFS_MSB:`LWBH_OFFS_LSB];
    assign base_f = instr[`LWBH_BASE_MSB:`LWBH_BASE_LSB];
    assign dest_f = instr[`LWBH_DEST_MSB:`LWBH_DEST_LSB];

    // Opcode match, size and offset form
    always_comb begin
        hit     = 1'b1;
        reg_off = 1'b0;
        size    = LWBH_WORD;
        imm32   = `LWBH_ZERO32;
        if (op7 == `LWBH_OP7_WORD_REG) begin
            reg_off = 1'b1;
            size    = LWBH_WORD;
        end else if (op7 == `LWBH_OP7_BYTE_REG) begin
            reg_off = 1'b1;
            size    = LWBH_BYTE;
        end else if (op7 == `LWBH_OP7_HALF_REG) begin
            reg_off = 1'b1;
            size    = LWBH_HALF;
        end else if (op5 == `LWBH_OP5_BYTE_IMM) begin
            size    = LWBH_BYTE;
            imm32   = {{`LWBH_IMM_PAD_B{1'b0}}, short_immediate_field};
        end else if (op5 == `LWBH_OP5_HALF_IMM) begin
            size    = LWBH_HALF;
            imm32   = {{`LWBH_IMM_PAD_H{1'b0}}, short_immediate_field, `LWBH_SCALE_H};
        end else if (op5 == `LWBH_OP5_WORD_IMM) begin
            size    = LWBH_WORD;
            imm32   = {{`LWBH_IMM_PAD_W{1'b0}}, short_immediate_field, `LWBH_SCALE_W};
        end else begin
            hit     = 1'b0;
        end
    end

endmodule

// >>> lwbh_load_unit.sv
// Load word, byte and halfword decode and execute unit
//
// Notes on behaviour
// - Register word load adds base and offset registers, reads four bytes, writes dest.
// - Word loaded into the program counter becomes a branch target.
// - Program counter load with bit 0 clear raises hard fault instead of branching.
// - Register word load matched on seven-bit prefix; offset, base, dest fields follow.
// - Immediate byte load adds unscaled five-bit immediate 0..31, zero-extends byte.
// - Immediate byte load matched on five-bit prefix; immediate zero-extended.
// - Register byte load adds base and offset, reads one byte, zero-extends it.
// - Register byte load matched on its seven-bit prefix with three register fields.
// - Immediate halfword load scales immediate by two, offsets 0..62, zero-extends.
// - Register halfword load adds registers, reads halfword, matched on seven-bit prefix.
// - Offset register is added to the base unshifted.
// - Sum is the access address, always added, base never written back.
// - Register fields are unsigned numbers into the general register file.
// - Zero immediate accesses memory exactly at the base value.
// - Immediate word load scales immediate by four, offsets 0..124.
`timescale 1ns/1ps
`include "lwbh_consts.svh"

module lwbh_load_unit
    import lwbh_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,

    // Instruction side
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr,
    input  wire logic        dest_ext,
    output logic             instr_ready,

    // Register file read
    output logic [3:0]       rf_raddr_base,
    output logic [3:0]       rf_raddr_offs,
    input  wire logic [31:0] rf_rdata_base,
    input  wire logic [31:0] rf_rdata_offs,

    // Register file write
    output logic             rf_we,
    output logic [3:0]       rf_waddr,
    output logic [31:0]      rf_wdata,

    // Memory load port
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    output lwbh_size_t       mem_size,
    input  wire logic        mem_rvalid,
    input  wire logic [31:0] mem_rdata,

    // Branch and fault events
    output logic             branch_valid,
    output logic [31:0]      branch_target,
    output logic             hard_fault_exception,
    output logic             not_load
);

    // Whole unit state and its next value
    lwbh_state_t st_r;
    lwbh_state_t st_nxt;

    // Decoder outputs
    lwbh_size_t  dec_size;
    logic        dec_hit;
    logic        dec_reg_off;
    logic [31:0] dec_imm32;
    logic [2:0]  dec_dest;
    logic [2:0]  dec_base;
    logic [2:0]  dec_offs;

    // Address path and returned data
    logic [31:0] offset_val;
    logic [32:0] sum_full;
    logic [31:0] eff_addr;
    logic [3:0]  lane_keep;
    logic [31:0] load_data;
    logic [31:0] br_target;
    logic [3:0]  fetch_dest;

    // Handshake and completion conditions
    logic        accept;
    logic        load_done;
    logic        pc_dest;
    logic        tbit_set;

    // Field and opcode decode
    lwbh_decode u_decode (
        .instr   (instr),
        .size    (dec_size),
        .hit     (dec_hit),
        .reg_off (dec_reg_off),
        .imm32   (dec_imm32),
        .dest_f  (dec_dest),
        .base_f  (dec_base),
        .offs_f  (dec_offs)
    );

    // Handshake toward fetch
    assign instr_ready = clk_en && (st_r.fsm == LWBH_IDLE);
    assign accept      = instr_valid && instr_ready;

    // Register file read indices straight from the fields
    assign rf_raddr_base = {1'b0, dec_base};
    assign rf_raddr_offs = {1'b0, dec_offs};

    // Address adder, offset unshifted, never subtracted
    assign offset_val = dec_reg_off ? rf_rdata_offs : dec_imm32;
    assign sum_full   = {1'b0, rf_rdata_base} + {1'b0, offset_val};

    // Carry out dropped on purpose, addresses wrap
    assign eff_addr   = sum_full[`LWBH_XLEN-1:0];
    assign fetch_dest = {dest_ext, dec_dest};

    // Byte lanes kept for the access size
    always_comb begin
        case (st_r.size)
            LWBH_BYTE: lane_keep = `LWBH_KEEP_B;
            LWBH_HALF: lane_keep = `LWBH_KEEP_H;
            LWBH_WORD: lane_keep = `LWBH_KEEP_W;
            default:   lane_keep = `LWBH_KEEP_W;
        endcase
    end

    // Zero extension lane by lane, dropped lanes read as zero
    for (genvar g = 0; g < `LWBH_LANES; g++) begin : g_lane
        assign load_data[g*`LWBH_LANE_W +: `LWBH_LANE_W] =
            lane_keep[g] ? mem_rdata[g*`LWBH_LANE_W +: `LWBH_LANE_W] : `LWBH_ZERO8;
    end

    // Completion and program counter checks on the returned word
    assign load_done = (st_r.fsm == LWBH_LOAD) && mem_rvalid;
    assign pc_dest   = (st_r.dest == `LWBH_PC_IDX);
    assign tbit_set  = load_data[`LWBH_TBIT];
    assign br_target = load_data & `LWBH_TBIT_CLR;

    // Next state of the whole unit
    always_comb begin
        st_nxt       = st_r;
        // Event pulses last one enabled cycle
        st_nxt.rf_we = 1'b0;
        st_nxt.br    = 1'b0;
        st_nxt.fault = 1'b0;
        st_nxt.miss  = 1'b0;
        case (st_r.fsm)
            LWBH_IDLE: begin
                if (accept) begin
                    if (dec_hit) begin
                        // Capture address, size and destination
                        st_nxt.fsm  = LWBH_LOAD;
                        st_nxt.addr = eff_addr;
                        st_nxt.size = dec_size;
                        st_nxt.dest = fetch_dest;
                    end else begin
                        // Opcode outside the load family
                        st_nxt.miss = 1'b1;
                    end
                end
            end
            LWBH_LOAD: begin
                // Destination written only once data is back
                if (load_done) begin
                    st_nxt.fsm = LWBH_IDLE;
                    // Program counter destination: branch or fault
                    if (pc_dest) begin
                        if (tbit_set) begin
                            st_nxt.br     = 1'b1;
                            st_nxt.br_tgt = br_target;
                        end else begin
                            st_nxt.fault  = 1'b1;
                        end
                    end else begin
                        // General register destination
                        st_nxt.rf_we    = 1'b1;
                        st_nxt.rf_waddr = st_r.dest;
                        st_nxt.rf_wdata = load_data;
                    end
                end
            end
            default: begin
                st_nxt.fsm = LWBH_IDLE;
            end
        endcase
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            // Constant reset values, clock enable ignored
            st_r.fsm      <= LWBH_IDLE;
            st_r.size     <= LWBH_WORD;
            st_r.dest     <= `LWBH_ZERO4;
            st_r.addr     <= `LWBH_ZERO32;
            st_r.rf_we    <= 1'b0;
            st_r.rf_waddr <= `LWBH_ZERO4;
            st_r.rf_wdata <= `LWBH_ZERO32;
            st_r.br       <= 1'b0;
            st_r.br_tgt   <= `LWBH_ZERO32;
            st_r.fault    <= 1'b0;
            st_r.miss     <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // Load port from the state register
    assign mem_req              = (st_r.fsm == LWBH_LOAD);
    assign mem_addr             = st_r.addr;
    assign mem_size             = st_r.size;

    // Register file write from the state register
    assign rf_we                = st_r.rf_we;
    assign rf_waddr             = st_r.rf_waddr;
    assign rf_wdata             = st_r.rf_wdata;

    // Branch, fault and miss pulses from the state register
    assign branch_valid         = st_r.br;
    assign branch_target        = st_r.br_tgt;
    assign hard_fault_exception = st_r.fault;
    assign not_load             = st_r.miss;

endmodule

// >>> lwbh_mem_model.sv
// Memory load port model answering each request after a set latency
`timescale 1ns/1ps
module lwbh_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [3:0]  mem_lat,
    output logic             mem_rvalid,
    output logic [31:0]      mem_rdata
);
    logic [3:0] cnt_r;
    // One answer pulse per request after mem_lat idle cycles
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !mem_req || mem_rvalid) begin
            mem_rvalid <= 1'b0;
            cnt_r      <= 4'h0;
        end else if (cnt_r == mem_lat) begin
            mem_rvalid <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    // Whole word with junk above the lane; inverted outside the answer
    assign mem_rdata = mem_rvalid ? mem_addr ^ 32'h5A5AC3C3 : ~(mem_addr ^ 32'h5A5AC3C3);
endmodule

// >>> lwbh_load_unit_asserts.sv
// Port assertions for the load unit
`timescale 1ns/1ps
module lwbh_load_unit_asserts
    import lwbh_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr,
    input  wire logic        dest_ext,
    input  wire logic        instr_ready,
    input  wire logic [31:0] rf_rdata_base,
    input  wire logic [31:0] rf_rdata_offs,
    input  wire logic        rf_we,
    input  wire logic [3:0]  rf_waddr,
    input  wire logic [31:0] rf_wdata,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  lwbh_size_t       mem_size,
    input  wire logic        mem_rvalid,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        branch_valid,
    input  wire logic [31:0] branch_target,
    input  wire logic        hard_fault_exception,
    input  wire logic        not_load
);
    logic [6:0]  o7;
    logic [4:0]  o5;
    logic        rg, hit, take, done;
    logic [1:0]  sc;
    logic [31:0] ea, ext;
    lwbh_size_t  es;
    logic [3:0]  dq_r;
    // Expected decode, address and size from the instruction bits
    assign o7 = instr[15:9];
    assign o5 = instr[15:11];
    assign rg = o7 == 7'h2C || o7 == 7'h2D || o7 == 7'h2E;
    assign hit = rg || o5 == 5'h0D || o5 == 5'h0F || o5 == 5'h11;
    assign sc = (o5 == 5'h0D) ? 2'h2 : (o5 == 5'h11) ? 2'h1 : 2'h0;
    assign ea = rf_rdata_base + (rg ? rf_rdata_offs : {27'h0000000, instr[10:6]} << sc);
    assign es = (o7 == 7'h2E || o5 == 5'h0F) ? LWBH_BYTE :
                (o7 == 7'h2D || o5 == 5'h11) ? LWBH_HALF : LWBH_WORD;
    assign ext = mem_size == LWBH_BYTE ? {24'h000000, mem_rdata[7:0]} :
                 mem_size == LWBH_HALF ? {16'h0000, mem_rdata[15:0]} : mem_rdata;
    assign take = instr_valid && instr_ready;
    assign done = mem_req && mem_rvalid && clk_en;
    // Destination index of the load in flight
    always_ff @(posedge ref_clk) begin
        if (take) begin
            dq_r <= {dest_ext, instr[2:0]};
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    load_start_a: assert property (take && hit |=> mem_req && !not_load)
        else $error("load not started");
    non_load_a: assert property (take && !hit |=> not_load && !mem_req)
        else $error("non-load not flagged");
    load_addr_a: assert property (take && hit |=> mem_addr == $past(ea))
        else $error("wrong load address");
    load_size_a: assert property (take && hit |=> mem_size == $past(es))
        else $error("wrong load size");
    req_hold_a: assert property (mem_req && !mem_rvalid |=> mem_req && $stable(mem_addr) && $stable(mem_size))
        else $error("request dropped early");
    busy_ready_a: assert property (mem_req |-> !instr_ready)
        else $error("ready while busy");
    write_data_a: assert property (done && dq_r != 4'hF |=> rf_we && rf_wdata == $past(ext) && rf_waddr == $past(dq_r))
        else $error("wrong register write");
    pc_dest_a: assert property (done && dq_r == 4'hF |=> !rf_we && branch_valid == $past(mem_rdata[0]) && hard_fault_exception != $past(mem_rdata[0]))
        else $error("wrong program counter load");
    branch_tgt_a: assert property (done && dq_r == 4'hF && mem_rdata[0] |=> branch_target == {$past(ext[31:1]), 1'b0})
        else $error("wrong branch target");
endmodule
bind lwbh_load_unit lwbh_load_unit_asserts chk_u (.*);

// >>> lwbh_load_unit_tb_top.sv
// Testbench for the load unit with one task per scenario
`timescale 1ns/1ps
module lwbh_load_unit_tb_top;
    import lwbh_pkg::*;
    logic        ref_clk, rst_b, clk_en, instr_valid, dest_ext, instr_ready, rf_we;
    logic        mem_req, mem_rvalid, branch_valid, hard_fault_exception, not_load;
    logic [15:0] instr;
    logic [3:0]  rf_raddr_base, rf_raddr_offs, rf_waddr, mem_lat;
    logic [31:0] rf_rdata_base, rf_rdata_offs, rf_wdata, mem_addr, mem_rdata, branch_target;
    lwbh_size_t  mem_size;
    logic [31:0] rf [16];
    int          err_total, checks;
    // Combinational register file read
    assign rf_rdata_base = rf[rf_raddr_base];
    assign rf_rdata_offs = rf[rf_raddr_offs];
    lwbh_load_unit dut_u (.*);
    lwbh_mem_model mem_u (.*);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Bounded single-cycle wait
    task automatic step(inout int n);
        @(posedge ref_clk);
        #1;
        n++;
        if (n > 20) begin
            err_total++;
            end_sim();
        end
    endtask
    // One load: kind 0 write, 1 branch, 2 fault, 3 non-load
    task automatic run(input logic [15:0] ins, input logic dx, input logic [31:0] bv,
                       input logic [31:0] ov, input logic [31:0] ea, input lwbh_size_t sz,
                       input int kind, input logic [3:0] lat);
        int n;
        logic [31:0] d;
        n = 0;
        rf[ins[8:6]] = ov;
        rf[ins[5:3]] = bv;
        mem_lat = lat;
        instr = ins;
        dest_ext = dx;
        instr_valid = 1'b1;
        while (!instr_ready) step(n);
        @(posedge ref_clk);
        #1 instr_valid = 1'b0;
        if (kind == 3) begin
            chk("not_load", not_load, 1);
            chk("mem_req", mem_req, 0);
            step(n);
            return;
        end
        chk("mem_addr", mem_addr, ea);
        chk("mem_size", mem_size, sz);
        while (!(rf_we || branch_valid || hard_fault_exception)) step(n);
        d = ea ^ 32'h5A5AC3C3;
        d = sz == LWBH_BYTE ? {24'h000000, d[7:0]} : sz == LWBH_HALF ? {16'h0000, d[15:0]} : d;
        chk("rf_we", rf_we, kind == 0);
        chk("branch_valid", branch_valid, kind == 1);
        chk("hard_fault", hard_fault_exception, kind == 2);
        if (kind == 0) begin
            chk("rf_wdata", rf_wdata, d);
            chk("rf_waddr", rf_waddr, {dx, ins[2:0]});
        end
        if (kind == 1) chk("branch_target", branch_target, {d[31:1], 1'b0});
    endtask
    // Register-offset forms, slow memory and a wrapping offset
    task automatic sc_reg_loads;
        run(16'h588B, 0, 32'h20000010, 32'h00000100, 32'h20000110, LWBH_WORD, 0, 3);
        run(16'h5D2E, 0, 32'h00000003, 32'hFFFFFFFF, 32'h00000002, LWBH_BYTE, 0, 0);
        run(16'h5BC1, 0, 32'h40000000, 32'h00000022, 32'h40000022, LWBH_HALF, 0, 1);
    endtask
    // Immediate forms at the largest and zero offsets
    task automatic sc_imm_loads;
        run(16'h7FD0, 0, 32'h80000000, 32'h00000000, 32'h8000001F, LWBH_BYTE, 0, 0);
        run(16'h781C, 0, 32'h12345677, 32'h00000000, 32'h12345677, LWBH_BYTE, 0, 2);
        run(16'h8FE5, 0, 32'h00000100, 32'h00000000, 32'h0000013E, LWBH_HALF, 0, 0);
        run(16'h6FF7, 0, 32'h00000200, 32'h00000000, 32'h0000027C, LWBH_WORD, 0, 1);
    endtask
    // Word loads into the program counter: legal and illegal state bit
    task automatic sc_pc_loads;
        run(16'h5847, 1, 32'h00000100, 32'h00000020, 32'h00000120, LWBH_WORD, 1, 2);
        run(16'h5847, 1, 32'h00000100, 32'h00000021, 32'h00000121, LWBH_WORD, 2, 0);
    endtask
    // Clock enable low holds the write pulse and keeps fetch refused
    task automatic sc_freeze;
        run(16'h588B, 0, 32'h20000010, 32'h00000100, 32'h20000110, LWBH_WORD, 0, 0);
        clk_en = 1'b0;
        repeat (2) begin
            @(posedge ref_clk);
            #1;
            chk("rf_we_frozen", rf_we, 1);
            chk("ready_frozen", instr_ready, 0);
        end
        clk_en = 1'b1;
        @(posedge ref_clk);
        #1;
        chk("rf_we_after", rf_we, 0);
    endtask
    // Instruction outside the load family
    task automatic sc_non_load;
        run(16'h0000, 0, 32'h00000000, 32'h00000000, 32'h00000000, LWBH_WORD, 3, 0);
    endtask
    initial begin
        err_total = 0;
        checks = 0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        instr_valid = 1'b0;
        instr = 16'h0000;
        dest_ext = 1'b0;
        mem_lat = 4'h0;
        foreach (rf[i]) rf[i] = 32'h00000000;
        repeat (3) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        sc_reg_loads();
        sc_imm_loads();
        sc_pc_loads();
        sc_non_load();
        sc_reg_loads();
        sc_freeze();
        end_sim();
    end
endmodule
